// ==== lctcon_pkg.sv ====
// Constants, types and layouts for the panel timing front end.
// Assumes one system clock; every pin except reset, CE and the register port is synchronised inside the top.
package lctcon_pkg;
  // ****************************************
  // Sizes and positions
  // ****************************************
  localparam int IN_W = 47;
  localparam int P_PCLK = 46;
  localparam int P_HS = 45;
  localparam int P_VS = 44;
  localparam int P_DE = 43;
  localparam int P_STBY = 3;
  localparam int P_CS = 2;
  localparam int P_SCL = 1;
  localparam int P_SDA = 0;
  localparam logic [2:0] SETTLE = 3'h7;
  // ****************************************
  // Line and frame timing
  // ****************************************
  localparam logic [10:0] SYNC_BP = 11'h058;
  localparam logic [10:0] HACT_800 = 11'h320;
  localparam logic [10:0] HACT_640 = 11'h280;
  localparam logic [10:0] HACT_320 = 11'h140;
  localparam logic [10:0] HTOT_480 = 11'h3a0;
  localparam logic [10:0] HTOT_600 = 11'h3e8;
  localparam logic [10:0] HTOT_VGA = 11'h2f8;
  localparam logic [9:0]  VTOT_480 = 10'h20d;
  localparam logic [9:0]  VTOT_600 = 10'h294;
  localparam logic [1:0]  RES_800X480 = 2'h0;
  localparam logic [1:0]  RES_800X600 = 2'h1;
  localparam logic [1:0]  RES_640X480 = 2'h2;
  localparam logic [3:0]  TEST_DIV = 4'h4;
  // ****************************************
  // Registers, serial and backlight
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic       CTRL_RST = 1'b1;
  localparam logic [6:0] SER_ADDR_MODE = 7'h00;
  localparam logic [3:0] SER_CMD_END = 4'h7;
  localparam logic [3:0] SER_END = 4'hf;
  localparam logic [1:0] BLM_UI = 2'h0;
  localparam logic [1:0] BLM_OFF = 2'h1;
  localparam logic [1:0] BLM_MOVE = 2'h2;
  localparam logic [1:0] BLM_STILL = 2'h3;
  localparam int GB_OEV = 2;
  localparam int GB_UD = 4;
  localparam int GB_CKV = 6;
  localparam int GB_STV1A = 8;
  localparam int GB_VERTICAL_START_SECOND = 10;
  localparam int GB_STV1B = 12;
  localparam int GB_STBN = 16;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic       latch_rise;
    logic       de_mode;
    logic [1:0] res;
    logic       dith_dis;
    logic       inv;
    logic       shift_fwd;
    logic       scan_up;
    logic       self_test;
    logic       master;
    logic       side_left;
    logic       dual_gate;
    logic       cascade;
    logic       abl_en_n;
    logic       ser_sel;
  } lctcon_cfg_s;
  localparam lctcon_cfg_s CFG_RST = 15'b0_1_00_1_0_1_0_0_1_0_0_1_1_1;
  typedef struct packed {
    logic [5:0] r;
    logic [5:0] g;
    logic [5:0] b;
  } lctcon_rgb_s;
  typedef enum logic [1:0] {SER_CMD, SER_WR, SER_RD} lctcon_ser_e;
endpackage : lctcon_pkg

// ==== lctcon_top.sv ====
// Pixel capture, line and frame timing, gate and backlight control.
// Assumes pins arrive unsynchronised and a register master on SYS_CLK.
//
// How it works
// [RULE_01] Pixels and syncs are latched on the pixel-clock edge the strap picks.
// [RULE_02] Input bus carries red, green, blue bytes, bit 0 least significant.
// [RULE_03] Without dithering only the upper six bits of each colour count.
// [RULE_04] Line and frame syncs are active-low; leading edge is the fall.
// [RULE_05] Framing strap low uses syncs; high uses data-valid as pixel mark.
// [RULE_06] Resolution pins pick one of four sizes and matching timing.
// [RULE_07] Sync framing: active pixels start 88 clocks after line sync.
// [RULE_08] Dithering on: two low bits dither into six-bit codes.
// [RULE_09] Select high: shared pins are serial; low: backlight mode pins.
// [RULE_10] Mode pins 00 UI, 01 off, 10 moving, 11 still (default).
// [RULE_11] Serial traffic counts only while chip select is low.
// [RULE_12] Global reset low clears all logic; cfg_r, lvl_r, ctrl_bl_r and ser_mode_r reset to nonzero defaults.
// [RULE_13] Standby low stops timing and releases all outputs; SERIAL_DATA_OE is not gated by standby.
// [RULE_14] Shift pin picks forward or reverse source channel order.
// [RULE_15] Scan pin picks which start output fires and gate direction.
// [RULE_16] Self-test makes its own pattern and needs no pixel clock.
// [RULE_17] Only a master drives gate and cascade controls.
// [RULE_18] Master side pin picks which cascade bus carries data.
// [RULE_19] Dual-gate pin enables dual-gate operation.
// [RULE_20] Dual gate: odd lines red-blue-green, even green-red-blue.
// [RULE_21] Cascade pin enables the cascade bus groups.
// [RULE_22] Adaptive backlight follows image gray level by PWM.
// [RULE_23] Backlight enable output switches the external controller.
// [RULE_24] Invert pin flips every bit of each six-bit code.
// [RULE_25] Straps are synchronised and applied at settle, at frame boundaries and on a self-test change.
// [RULE_26] Serial data is driven only in the read-data phase.
`timescale 1ns/1ps
module lctcon_top import lctcon_pkg::*; #(
  parameter logic [10:0] HTOT_QVGA = 11'h198,
  parameter logic [9:0]  VTOT_QVGA = 10'h106
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  input  wire logic        PIXEL_CLOCK_INPUT,
  input  wire logic [23:0] PIXEL_DATA_IN,
  input  wire logic        LINE_SYNC_IN,
  input  wire logic        FRAME_SYNC_IN,
  input  wire logic        PIXEL_VALID_IN,
  input  wire logic        LATCH_EDGE_SELECT,
  input  wire logic        FRAMING_SELECT,
  input  wire logic [1:0]  RESOLUTION_SELECT,
  input  wire logic        DITHER_DISABLE,
  input  wire logic        CODE_INVERT_ENABLE,
  input  wire logic        SOURCE_SHIFT_DIRECTION,
  input  wire logic        GATE_SCAN_DIRECTION,
  input  wire logic        SELF_TEST_PATTERN_SELECT,
  input  wire logic        MASTER_SLAVE_SELECT,
  input  wire logic        MASTER_SIDE_SELECT,
  input  wire logic        DUAL_GATE_ENABLE,
  input  wire logic        CASCADE_ENABLE,
  input  wire logic        ADAPTIVE_BACKLIGHT_ENABLE_N,
  input  wire logic        SERIAL_OR_PIN_BACKLIGHT_SELECT,
  input  wire logic        STANDBY_N,
  input  wire logic        SERIAL_CHIP_SELECT_N,
  input  wire logic        SERIAL_CLOCK_IN,
  input  wire logic        SERIAL_DATA_IN,
  output logic             SERIAL_DATA_OUT,
  output logic             SERIAL_DATA_OE,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA,
  output logic [17:0]      PIX_OUT,
  output logic             PIX_OUT_VALID,
  output logic [10:0]      PIX_OUT_INDEX,
  output logic             VERTICAL_START_FIRST,
  output logic             VERTICAL_START_SECOND,
  output logic             GATE_DIRECTION_OUT,
  output logic             GATE_OE,
  output logic [17:0]      RIGHT_CASCADE_BUS,
  output logic             RIGHT_CASCADE_OE,
  output logic [17:0]      LEFT_CASCADE_BUS,
  output logic             LEFT_CASCADE_OE,
  output logic             BACKLIGHT_PWM_OUT,
  output logic             BACKLIGHT_ENABLE_OUT,
  output logic             OUT_OE
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [10:0] hact_of(input logic [1:0] res);
    unique case (res)
      RES_800X480, RES_800X600: hact_of = HACT_800;
      RES_640X480:              hact_of = HACT_640;
      default:                  hact_of = HACT_320;
    endcase
  endfunction : hact_of

  function automatic logic [5:0] conv(input logic [7:0] d,
      input logic [1:0] thr, input logic dith, input logic inv);
    logic [5:0] c;
    c = d[7:2];
    if (dith && c != 6'h3f && d[1:0] > thr) begin
      c = c + 6'h01;
    end
    conv = inv ? ~c : c;
  endfunction : conv

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [IN_W-1:0] in_raw, s1_r, s2_r, s3_r, filt_r;
  logic [3:0]      pv_r;
  lctcon_cfg_s     strap_f, cfg_r;
  logic            run, hs_fall, vs_fall, rise, fall, scl_rise, scl_fall;
  assign in_raw = {PIXEL_CLOCK_INPUT, LINE_SYNC_IN, FRAME_SYNC_IN,
                   PIXEL_VALID_IN, PIXEL_DATA_IN, LATCH_EDGE_SELECT,
                   FRAMING_SELECT, RESOLUTION_SELECT, DITHER_DISABLE,
                   CODE_INVERT_ENABLE, SOURCE_SHIFT_DIRECTION,
                   GATE_SCAN_DIRECTION, SELF_TEST_PATTERN_SELECT,
                   MASTER_SLAVE_SELECT, MASTER_SIDE_SELECT,
                   DUAL_GATE_ENABLE, CASCADE_ENABLE,
                   ADAPTIVE_BACKLIGHT_ENABLE_N,
                   SERIAL_OR_PIN_BACKLIGHT_SELECT, STANDBY_N,
                   SERIAL_CHIP_SELECT_N, SERIAL_CLOCK_IN, SERIAL_DATA_IN};
  assign strap_f = filt_r[18:4];
  // [RULE_13] Standby stops timing
  assign run = filt_r[P_STBY];
  // [RULE_04] Leading edges are falls
  assign hs_fall = !filt_r[P_HS] && pv_r[2];
  assign vs_fall = !filt_r[P_VS] && pv_r[1];
  assign rise = filt_r[P_PCLK] && !pv_r[3];
  assign fall = !filt_r[P_PCLK] && pv_r[3];
  assign scl_rise = filt_r[P_SCL] && !pv_r[0];
  assign scl_fall = !filt_r[P_SCL] && pv_r[0];

  // [RULE_12] Global reset clears all
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
      pv_r <= '0;
    end else if (CE) begin
      s1_r <= in_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
      pv_r <= {filt_r[P_PCLK], filt_r[P_HS], filt_r[P_VS], filt_r[P_SCL]};
    end
  end

  // ****************************************
  // Pixel tick and timing counters
  // ****************************************
  logic [3:0]  div_r;
  logic [2:0]  settle_r;
  logic [10:0] h_cnt_r, pix_idx_r, cur_idx, hact, htot;
  logic [9:0]  v_cnt_r, vtot;
  logic        hs_pend_r, de_q_r, tick, ls, fs, bound, win, pix_ok;
  // [RULE_06] Resolution decode
  assign hact = hact_of(cfg_r.res);
  always_comb begin
    unique case (cfg_r.res)
      RES_800X480: begin htot = HTOT_480; vtot = VTOT_480; end
      RES_800X600: begin htot = HTOT_600; vtot = VTOT_600; end
      RES_640X480: begin htot = HTOT_VGA; vtot = VTOT_480; end
      default:     begin htot = HTOT_QVGA; vtot = VTOT_QVGA; end
    endcase
  end
  // [RULE_01] Latch edge choice
  // [RULE_16] Self-test runs from divider
  assign tick = run && (cfg_r.self_test ? div_r == TEST_DIV - 4'h1
                       : (cfg_r.latch_rise ? rise : fall));
  // [RULE_05] Framing source
  assign ls = tick && (cfg_r.self_test ? h_cnt_r == htot - 11'h001
              : cfg_r.de_mode ? (filt_r[P_DE] && !de_q_r)
              : (hs_pend_r || hs_fall));
  assign fs = cfg_r.self_test ? (ls && v_cnt_r == vtot - 10'h001)
                              : vs_fall;
  // [RULE_25] Apply straps at frame boundary
  assign bound = fs || strap_f.self_test != cfg_r.self_test;
  // [RULE_07] Window starts 88 clocks in
  assign win = !ls && h_cnt_r >= SYNC_BP - 11'h001
               && h_cnt_r < SYNC_BP - 11'h001 + hact;
  assign pix_ok = tick && ((cfg_r.de_mode && !cfg_r.self_test)
                           ? filt_r[P_DE] : win);
  assign cur_idx = ls ? 11'h000 : pix_idx_r;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_r <= CFG_RST;
      settle_r <= '0;
    end else if (CE) begin
      if (settle_r != SETTLE) begin
        settle_r <= settle_r + 3'h1;
      end
      if (settle_r == SETTLE - 3'h1 || (settle_r == SETTLE && bound)) begin
        cfg_r <= strap_f;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_r <= '0;
      h_cnt_r <= '0;
      v_cnt_r <= '0;
      pix_idx_r <= '0;
      hs_pend_r <= 1'b0;
      de_q_r <= 1'b0;
    end else if (CE) begin
      div_r <= (div_r == TEST_DIV - 4'h1) ? 4'h0 : div_r + 4'h1;
      hs_pend_r <= run && !tick && (hs_pend_r || hs_fall);
      if (!run || ls) begin
        h_cnt_r <= '0;
      end else if (tick && h_cnt_r != 11'h7ff) begin
        h_cnt_r <= h_cnt_r + 11'h001;
      end
      if (!run) begin
        v_cnt_r <= '0;
      end else if (fs) begin
        v_cnt_r <= ls ? 10'h000 : 10'h3ff;
      end else if (ls) begin
        v_cnt_r <= v_cnt_r + 10'h001;
      end
      if (tick) begin
        de_q_r <= filt_r[P_DE];
      end
      if (pix_ok) begin
        pix_idx_r <= cur_idx + 11'h001;
      end else if (ls) begin
        pix_idx_r <= '0;
      end
    end
  end

  // ****************************************
  // Pixel data path
  // ****************************************
  logic [23:0] src;
  logic [1:0]  thr;
  lctcon_rgb_s c;
  logic [17:0] pixw, gw;
  logic        dith, stv, ckv_r;
  // [RULE_02] Red high byte, blue low byte
  assign src = cfg_r.self_test ? {{8{h_cnt_r[8]}}, {8{h_cnt_r[7]}},
                                  {8{h_cnt_r[6]}}} : filt_r[42:19];
  assign thr = {h_cnt_r[0] ^ v_cnt_r[0], v_cnt_r[0]};
  // [RULE_08] Dither unless disabled
  assign dith = !cfg_r.dith_dis;
  // [RULE_03] Upper six bits only
  // [RULE_24] Optional code inversion
  assign c.r = conv(src[23:16], thr, dith, cfg_r.inv);
  assign c.g = conv(src[15:8], thr, dith, cfg_r.inv);
  assign c.b = conv(src[7:0], thr, dith, cfg_r.inv);
  // [RULE_19] Dual gate colour order
  // [RULE_20] Odd and even line order
  assign pixw = !cfg_r.dual_gate ? {c.r, c.g, c.b}
              : v_cnt_r[0] ? {c.r, c.b, c.g} : {c.g, c.r, c.b};
  assign stv = run && v_cnt_r == 10'h000;
  always_comb begin
    gw = '0;
    gw[GB_OEV] = !win;
    gw[GB_UD] = cfg_r.scan_up;
    gw[GB_CKV] = ckv_r;
    gw[GB_STV1A] = stv && cfg_r.scan_up;
    gw[GB_STV1B] = stv && cfg_r.scan_up;
    gw[GB_VERTICAL_START_SECOND] = stv && !cfg_r.scan_up;
    gw[GB_STBN] = !pix_ok;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PIX_OUT <= '0;
      PIX_OUT_VALID <= 1'b0;
      PIX_OUT_INDEX <= '0;
    end else if (CE) begin
      PIX_OUT_VALID <= pix_ok;
      if (pix_ok) begin
        PIX_OUT <= pixw;
        // [RULE_14] Source channel order
        PIX_OUT_INDEX <= cfg_r.shift_fwd ? cur_idx
                                         : hact - 11'h001 - cur_idx;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ckv_r <= 1'b0;
      VERTICAL_START_FIRST <= 1'b0;
      VERTICAL_START_SECOND <= 1'b0;
      GATE_DIRECTION_OUT <= 1'b0;
      GATE_OE <= 1'b0;
      OUT_OE <= 1'b0;
      RIGHT_CASCADE_BUS <= '0;
      LEFT_CASCADE_BUS <= '0;
      RIGHT_CASCADE_OE <= 1'b0;
      LEFT_CASCADE_OE <= 1'b0;
    end else if (CE) begin
      if (ls) begin
        ckv_r <= !ckv_r;
      end
      // [RULE_15] Start output and direction
      VERTICAL_START_FIRST <= cfg_r.master && stv && cfg_r.scan_up;
      VERTICAL_START_SECOND <= cfg_r.master && stv && !cfg_r.scan_up;
      GATE_DIRECTION_OUT <= cfg_r.scan_up;
      // [RULE_13] Release outputs in standby
      OUT_OE <= run;
      // [RULE_17] Master only drives gates
      GATE_OE <= run && cfg_r.master;
      RIGHT_CASCADE_OE <= run && cfg_r.master;
      LEFT_CASCADE_OE <= run && cfg_r.master;
      // [RULE_18] Side picks data bus
      // [RULE_21] Cascade enable
      RIGHT_CASCADE_BUS <= (cfg_r.cascade && cfg_r.side_left) ? pixw : gw;
      LEFT_CASCADE_BUS <= (cfg_r.cascade && !cfg_r.side_left) ? pixw : gw;
    end
  end

  // ****************************************
  // Serial port
  // ****************************************
  lctcon_ser_e ser_st_r;
  logic [3:0]  ser_cnt_r;
  logic [6:0]  ser_sh_r, ser_addr_r;
  logic [7:0]  ser_rd_r;
  logic [1:0]  ser_mode_r;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ser_st_r <= SER_CMD;
      ser_cnt_r <= '0;
      ser_sh_r <= '0;
      ser_addr_r <= '0;
      ser_rd_r <= '0;
      ser_mode_r <= BLM_STILL;
      SERIAL_DATA_OUT <= 1'b0;
      SERIAL_DATA_OE <= 1'b0;
    end else if (CE) begin
      // [RULE_09] Serial only when selected
      // [RULE_11] Ignore while deselected
      if (filt_r[P_CS] || !cfg_r.ser_sel || settle_r != SETTLE) begin
        ser_st_r <= SER_CMD;
        ser_cnt_r <= '0;
        SERIAL_DATA_OE <= 1'b0;
      end else if (scl_rise) begin
        ser_sh_r <= {ser_sh_r[5:0], filt_r[P_SDA]};
        ser_cnt_r <= ser_cnt_r + 4'h1;
        unique case (ser_st_r)
          SER_CMD: if (ser_cnt_r == SER_CMD_END) begin
            ser_st_r <= ser_sh_r[6] ? SER_RD : SER_WR;
            ser_addr_r <= {ser_sh_r[5:0], filt_r[P_SDA]};
            ser_rd_r <= {6'h00, ser_mode_r};
          end
          SER_WR: if (ser_cnt_r == SER_END) begin
            ser_st_r <= SER_CMD;
            if (ser_addr_r == SER_ADDR_MODE) begin
              ser_mode_r <= {ser_sh_r[0], filt_r[P_SDA]};
            end
          end
          SER_RD: if (ser_cnt_r == SER_END) begin
            ser_st_r <= SER_CMD;
          end
        endcase
      end else if (scl_fall) begin
        // [RULE_26] Drive only in read phase
        SERIAL_DATA_OE <= ser_st_r == SER_RD;
        SERIAL_DATA_OUT <= ser_rd_r[7];
        ser_rd_r <= {ser_rd_r[6:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Backlight and register port
  // ****************************************
  logic [7:0] gray, fmax_r, lvl_r, duty, pwm_r;
  logic [1:0] blm;
  logic       ctrl_bl_r;
  assign gray = (src[23:16] > src[15:8])
              ? (src[23:16] > src[7:0] ? src[23:16] : src[7:0])
              : (src[15:8] > src[7:0] ? src[15:8] : src[7:0]);
  // [RULE_09] Pin mode select, data pin MSB
  assign blm = cfg_r.ser_sel ? ser_mode_r
                             : {filt_r[P_SDA], filt_r[P_SCL]};
  // [RULE_10] Backlight mode decode
  always_comb begin
    unique case (blm)
      BLM_UI:   duty = lvl_r;
      BLM_OFF:  duty = 8'hff;
      BLM_MOVE: duty = lvl_r + (~lvl_r >> 2);
      default:  duty = lvl_r + (~lvl_r >> 1);
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fmax_r <= '0;
      lvl_r <= 8'hff;
      pwm_r <= '0;
      ctrl_bl_r <= CTRL_RST;
      REG_RDATA <= '0;
      BACKLIGHT_PWM_OUT <= 1'b0;
      BACKLIGHT_ENABLE_OUT <= 1'b0;
    end else if (CE) begin
      pwm_r <= pwm_r + 8'h01;
      if (fs) begin
        fmax_r <= '0;
        lvl_r <= fmax_r;
      end else if (pix_ok && gray > fmax_r) begin
        fmax_r <= gray;
      end
      // [RULE_22] Adaptive PWM or plain level
      BACKLIGHT_PWM_OUT <= cfg_r.abl_en_n ? ctrl_bl_r
                         : (pwm_r < duty || duty == 8'hff);
      // [RULE_23] Backlight enable
      BACKLIGHT_ENABLE_OUT <= ctrl_bl_r && run;
      if (REG_WR && REG_ADDR == ADDR_CTRL) begin
        ctrl_bl_r <= REG_WDATA[0];
      end
      REG_RDATA <= '0;
      if (REG_RD && REG_ADDR == ADDR_CTRL) begin
        REG_RDATA <= {31'h0, ctrl_bl_r};
      end else if (REG_RD && REG_ADDR == ADDR_STAT) begin
        REG_RDATA <= {7'h00, cfg_r, v_cnt_r};
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN || !CE);
  sequence s_line_go;
    tick && !cfg_r.self_test && !cfg_r.de_mode && (hs_pend_r || hs_fall);
  endsequence
  sequence s_sleep;
    !run ##1 !run;
  endsequence

  chk_edge_pick: assert property ( // RULE_01
    tick && !cfg_r.self_test |-> filt_r[P_PCLK] == cfg_r.latch_rise
                                 && pv_r[3] != cfg_r.latch_rise)
    else $error("pixel latched on wrong edge");
  chk_de_frame: assert property ( // RULE_05
    tick && cfg_r.de_mode && !cfg_r.self_test |-> pix_ok == filt_r[P_DE])
    else $error("data-valid framing wrong");
  chk_res_width: assert property ( // RULE_06
    pix_ok && !cfg_r.de_mode |-> cur_idx < hact)
    else $error("pixel beyond active width");
  chk_bp_fixed: assert property ( // RULE_07
    s_line_go |=> h_cnt_r == 11'h000 ##0 (!pix_ok [*2]))
    else $error("pixel too soon after line sync");
  chk_scan_side: assert property ( // RULE_15
    VERTICAL_START_FIRST |-> !VERTICAL_START_SECOND && GATE_DIRECTION_OUT)
    else $error("start pulse on wrong output");
  chk_hiz_standby: assert property ( // RULE_13
    s_sleep |-> !OUT_OE && !GATE_OE && !PIX_OUT_VALID)
    else $error("outputs driven in standby");
  chk_slave_quiet: assert property ( // RULE_17
    !cfg_r.master ##1 !cfg_r.master |-> !RIGHT_CASCADE_OE && !GATE_OE)
    else $error("slave drives gate controls");
  chk_strap_hold: assert property ( // RULE_25
    settle_r == SETTLE && !bound |=> $stable(cfg_r))
    else $error("mode changed inside a frame");
  chk_cs_ignore: assert property ( // RULE_11
    filt_r[P_CS] |=> ser_cnt_r == 4'h0 && !SERIAL_DATA_OE)
    else $error("serial active while deselected");
  chk_sda_drive: assert property ( // RULE_26
    $rose(SERIAL_DATA_OE) |-> $past(ser_st_r) == SER_RD)
    else $error("serial data driven outside read");
endmodule : lctcon_top

// ==== lctcon_host.sv ====
// Host display controller model: pixel clock, RGB bytes, syncs.
// Assumes SYS_CLK and its own active-low reset from the bench.
`timescale 1ns/1ps
module lctcon_host (
  input  wire logic   clk,
  input  wire logic   rst_n,
  output logic        pclk,
  output logic [23:0] data,
  output logic        hs,
  output logic        vs
);
  // ****
  // Line of 420 ticks, frame of 3 lines
  // ****
  logic [2:0] div_r;
  logic [8:0] h_r;
  logic [1:0] l_r;
  integer     seed;
  initial seed = 26733;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 3'h0;
      h_r <= 9'h0;
      l_r <= 2'h0;
      pclk <= 1'b0;
      data <= 24'h0;
      hs <= 1'b1;
      vs <= 1'b1;
    end else begin
      div_r <= div_r + 3'h1;
      pclk <= (div_r < 3'h4);
      if (div_r == 3'h0) begin
        // red green blue, low bits low
        data <= $random(seed) & 24'hfcfcfc;
        hs <= (h_r >= 9'h00a);
        vs <= !(l_r == 2'h0 && h_r < 9'h00a);
        h_r <= (h_r == 9'h1a3) ? 9'h0 : h_r + 9'h1;
        if (h_r == 9'h1a3) begin
          l_r <= (l_r == 2'h2) ? 2'h0 : l_r + 2'h1;
        end
      end
    end
  end
endmodule : lctcon_host

// ==== tb.sv ====
// Bench: host model, reference queue, register and pin checks.
// Assumes the timing top, its package and the host model.
`timescale 1ns/1ps
module tb import lctcon_pkg::*;;
  // ****
  // Signals and instances
  // ****
  logic        clk, rst_n, host_rst_n, stby_n, pclk, hs, vs, wr, rd;
  logic        sda_oe, pv, vs1, vs2, gdir, goe, blen, ooe, hs_q, vs_q, inv_a;
  logic        cs, scl, sda, sda_o, pwm, roe, loe;
  logic [7:0]  sr;
  logic [23:0] d;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [17:0] pix, rbus;
  logic [10:0] pi;
  logic [28:0] x;
  logic [28:0] expq[$];
  lctcon_cfg_s cfg;
  int          cnt, i, miscompares, samples_checked;
  lctcon_host host (.clk(clk), .rst_n(host_rst_n), .pclk(pclk), .data(d),
    .hs(hs), .vs(vs));
  lctcon_top uut (.SYS_CLK(clk), .RESETN(rst_n), .CE(1'b1),
    .PIXEL_CLOCK_INPUT(pclk), .PIXEL_DATA_IN(d), .LINE_SYNC_IN(hs),
    .FRAME_SYNC_IN(vs), .PIXEL_VALID_IN(1'b0),
    .LATCH_EDGE_SELECT(cfg.latch_rise), .FRAMING_SELECT(cfg.de_mode),
    .RESOLUTION_SELECT(cfg.res), .DITHER_DISABLE(cfg.dith_dis),
    .CODE_INVERT_ENABLE(cfg.inv), .SOURCE_SHIFT_DIRECTION(cfg.shift_fwd),
    .GATE_SCAN_DIRECTION(cfg.scan_up),
    .SELF_TEST_PATTERN_SELECT(cfg.self_test),
    .MASTER_SLAVE_SELECT(cfg.master), .MASTER_SIDE_SELECT(cfg.side_left),
    .DUAL_GATE_ENABLE(cfg.dual_gate), .CASCADE_ENABLE(cfg.cascade),
    .ADAPTIVE_BACKLIGHT_ENABLE_N(cfg.abl_en_n),
    .SERIAL_OR_PIN_BACKLIGHT_SELECT(cfg.ser_sel), .STANDBY_N(stby_n),
    .SERIAL_CHIP_SELECT_N(cs), .SERIAL_CLOCK_IN(scl),
    .SERIAL_DATA_IN(sda), .SERIAL_DATA_OUT(sda_o), .SERIAL_DATA_OE(sda_oe),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .PIX_OUT(pix), .PIX_OUT_VALID(pv),
    .PIX_OUT_INDEX(pi), .VERTICAL_START_FIRST(vs1),
    .VERTICAL_START_SECOND(vs2), .GATE_DIRECTION_OUT(gdir), .GATE_OE(goe),
    .RIGHT_CASCADE_BUS(rbus), .RIGHT_CASCADE_OE(roe), .LEFT_CASCADE_BUS(),
    .LEFT_CASCADE_OE(loe), .BACKLIGHT_PWM_OUT(pwm),
    .BACKLIGHT_ENABLE_OUT(blen), .OUT_OE(ooe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] r);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask : reg_rd
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] w);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= w;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic ser_xfer(input logic [15:0] w, output logic [7:0] r);
    cs <= 1'b0;
    for (i = 15; i >= 0; i--) begin
      repeat (8) @(posedge clk);
      scl <= 1'b0;
      sda <= w[i];
      repeat (8) @(posedge clk);
      if (i < 8) r[i] = sda_o;
      scl <= 1'b1;
    end
    repeat (8) @(posedge clk);
    cs <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : ser_xfer
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // ****
  // Reference model of the sync-framed pixel path
  // ****
  initial begin
    cnt = 9999;
    hs_q = 1'b1;
    vs_q = 1'b1;
    inv_a = 1'b0;
  end
  always @(negedge pclk) begin
    if (!vs && vs_q) inv_a = cfg.inv;
    cnt = (!hs && hs_q) ? 0 : cnt + 1;
    hs_q = hs;
    vs_q = vs;
    if (cnt >= 88 && cnt < 408)
      expq.push_back({11'(cnt - 88),
        {d[23:18], d[15:10], d[7:2]} ^ {18{inv_a}}});
  end
  always @(posedge clk) begin
    if (pv === 1'b1 && stby_n) begin
      x = (expq.size() > 0) ? expq.pop_front() : 29'h1fffffff;
      chk(32'(pix), 32'(x[17:0]));
      chk(32'(pi), 32'(x[28:18]));
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    rst_n = 1'b0;
    host_rst_n = 1'b0;
    stby_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    cs = 1'b1;
    scl = 1'b1;
    sda = 1'b1;
    cfg = 15'h1da7;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    reg_rd(ADDR_CTRL, v);
    chk(v, 32'h1);
    reg_rd(ADDR_STAT, v);
    chk(32'(v[24:10]), 32'(cfg));
    reg_rd(4'h8, v);
    chk(v, 32'h0);
    chk(32'({sda_o, sda_oe}), 32'h0);
    reg_wr(ADDR_CTRL, 32'h0);
    for (i = 0; i < 8 && blen !== 1'b0; i++) @(posedge clk);
    chk(32'(blen), 32'h0);
    chk(32'(pwm), 32'h0);
    reg_wr(ADDR_CTRL, 32'h1);
    $display("register test done");
    ser_xfer(16'h0001, sr);
    ser_xfer(16'h8000, sr);
    chk(32'(sr), 32'({6'h00, BLM_OFF}));
    $display("serial test done");
    host_rst_n <= 1'b1;
    repeat (6720) @(posedge clk);
    cfg <= cfg ^ 15'h0280;
    repeat (3760) @(posedge clk);
    chk(32'({gdir, vs2, vs1, goe}), 32'h5);
    chk(32'({rbus[GB_VERTICAL_START_SECOND], rbus[GB_STV1A], rbus[GB_UD]}), 32'h4);
    cfg <= cfg ^ 15'h0020;
    repeat (10000) @(posedge clk);
    chk(32'({roe, goe, vs2, vs1}), 32'h0);
    $display("pixel test done");
    stby_n <= 1'b0;
    repeat (12) @(posedge clk);
    chk(32'({ooe, goe, roe, loe}), 32'h0);
    $display("standby test done");
    end_of_test;
  end
endmodule : tb
